//--- rtl/dp_tx_defs.svh
// constants for the source-side link bring-up and training block
`ifndef DP_TX_DEFS_SVH
`define DP_TX_DEFS_SVH

// register offsets (byte addresses)
`define OFS_LINK_RATE_CODE 12'h000
`define OFS_LANE_COUNT 12'h004
`define OFS_ENH_FRAMING 12'h008
`define OFS_TRAIN_PATTERN 12'h00C
`define OFS_SCR_BYPASS 12'h010
`define OFS_SERDES_RESET 12'h01C
`define OFS_SERDES_RATE 12'h020
`define OFS_SERDES_READY 12'h024
`define OFS_TX_ENABLE 12'h080
`define OFS_STREAM_ENABLE 12'h084
`define OFS_SCR_FORCE_RST 12'h0C0
`define OFS_STREAM_ATTR 12'h180
`define OFS_LINE_CODE_CFG 12'h200

// reset values
`define RST_SERDES_RESET 1'h1
`define RST_LINE_CODE_CFG 1'h1
`define RST_SERDES_RATE 8'h00
`define RST_LINK_RATE 8'h00
`define RST_LANE_COUNT 5'h01

// field values
`define PAT_NONE 2'h0
`define PAT_ONE 2'h1
`define PAT_TWO 2'h2
`define PAT_THREE 2'h3
`define SERDES_ALL_READY 6'h3F

// link symbols, reseed period, scrambler seed and taps, last pattern phase
`define SYM_D10_2 8'h4A
`define SYM_D11_6 8'hCB
`define SYM_K28_5 8'hBC
`define SYM_K28_0 8'h1C
`define SYM_IDLE 8'h00
`define BS_PERIOD 9'h1FF
`define LFSR_SEED 16'hFFFF
`define LFSR_TAPS 16'h0039
`define PHASE_LAST 4'h9

`endif

//--- rtl/dp_tx_pkg.sv
// types shared by the source-side training block
`default_nettype none
package dp_tx_pkg;
	// one-hot training state
	typedef enum logic [3:0] {
		TRAIN_OFF = 4'h1,
		TRAIN_TP1 = 4'h2,
		TRAIN_TP2 = 4'h4,
		TRAIN_TP3 = 4'h8
	} trainState_t;

	typedef struct packed {
		logic [7:0] data;
		logic isK;
	} symbol_t;
endpackage
`default_nettype wire

//--- rtl/scrambler_if.sv
// symbol hand-over between datapath selection and the scrambler
`default_nettype none
interface scrambler_if;
	dp_tx_pkg::symbol_t rawSym;
	logic bypass;
	logic seedReset;
	dp_tx_pkg::symbol_t lineSym;

	modport feed (output rawSym, output bypass, output seedReset,
		input lineSym);
	modport scr (input rawSym, input bypass, input seedReset,
		output lineSym);
endinterface
`default_nettype wire

//--- rtl/scrambler.sv
// link-layer scrambler, one symbol per clock, registered output
`include "dp_tx_defs.svh"
`default_nettype none
module scrambler (
	input wire logic clk,
	input wire logic rst_n,
	scrambler_if.scr port
);
	logic [15:0] lfsr;
	logic [15:0] next_lfsr;
	logic [7:0] mask;
	dp_tx_pkg::symbol_t outSym;

	// serial lfsr unrolled over one byte; msb of state is key bit
	function automatic logic [23:0] step8(input logic [15:0] s);
		logic [15:0] st;
		logic [7:0] k;
		st = s;
		k = 8'h00;
		for (int i = 0; i < 8; i++) begin
			k[i] = st[15];
			st = {st[14:0], 1'b0} ^ (st[15] ? `LFSR_TAPS : 16'h0000);
		end
		return {st, k};
	endfunction

	assign {next_lfsr, mask} = step8(lfsr);
	assign port.lineSym = outSym;

	// state advances on every symbol; a seed reset restarts the sequence
	always_ff @(posedge clk) begin
		if (!rst_n || port.seedReset) begin
			lfsr <= `LFSR_SEED;
		end else begin
			lfsr <= next_lfsr;
		end
	end

	// control characters are never scrambled, bypass passes data straight
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			outSym <= '0;
		end else begin
			outSym.isK <= port.rawSym.isK;
			outSym.data <= (port.bypass || port.rawSym.isK) ?
				port.rawSym.data : port.rawSym.data ^ mask;
		end
	end
endmodule
`default_nettype wire

//--- rtl/dp_tx_link_ctrl.sv
// source link bring-up registers, training pattern generator, datapath
`include "dp_tx_defs.svh"
`default_nettype none
module dp_tx_link_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	output logic [31:0] regRdData,
	output logic regRdValid,
	input wire logic [5:0] serdesReadyPins,
	input wire logic [7:0] videoData,
	input wire logic videoIsK,
	output logic [7:0] txData,
	output logic txIsK,
	output logic serdesReset,
	output logic [7:0] serdesRate,
	output logic txEnable,
	output logic lineCodeEnable,
	output logic [4:0] laneCount,
	output logic [7:0] linkRateCode,
	output logic enhancedFraming,
	output logic [31:0] streamAttributes,
	output logic streamEnable,
	output logic trainingActive
);
	scrambler_if scrBus ();

	logic [1:0] patternSel;
	logic scrBypass;
	logic [5:0] readySync1;
	logic [5:0] readySync2;
	logic [5:0] readySync3;
	logic [5:0] readyFlags;
	logic forceScrReset;
	logic [8:0] bsCount;
	logic [3:0] phase;
	dp_tx_pkg::trainState_t state;
	dp_tx_pkg::trainState_t next_state;
	dp_tx_pkg::symbol_t patSym;
	dp_tx_pkg::symbol_t selSym;

	// address decode of writes
	wire wrRate = regWrEn && regAddr == `OFS_LINK_RATE_CODE;
	wire wrLanes = regWrEn && regAddr == `OFS_LANE_COUNT;
	wire wrEnh = regWrEn && regAddr == `OFS_ENH_FRAMING;
	wire wrPat = regWrEn && regAddr == `OFS_TRAIN_PATTERN;
	wire wrByp = regWrEn && regAddr == `OFS_SCR_BYPASS;
	wire wrSRst = regWrEn && regAddr == `OFS_SERDES_RESET;
	wire wrSRate = regWrEn && regAddr == `OFS_SERDES_RATE;
	wire wrTxEn = regWrEn && regAddr == `OFS_TX_ENABLE;
	wire wrStream = regWrEn && regAddr == `OFS_STREAM_ENABLE;
	wire wrForce = regWrEn && regAddr == `OFS_SCR_FORCE_RST;
	wire wrAttr = regWrEn && regAddr == `OFS_STREAM_ATTR;
	wire wrLine = regWrEn && regAddr == `OFS_LINE_CODE_CFG;

	// control registers written by the host
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			linkRateCode <= `RST_LINK_RATE;
			laneCount <= `RST_LANE_COUNT;
			enhancedFraming <= 1'b0;
			patternSel <= `PAT_NONE;
			scrBypass <= 1'b0;
			serdesReset <= `RST_SERDES_RESET;
			serdesRate <= `RST_SERDES_RATE;
		end else begin
			if (wrRate) linkRateCode <= regWrData[7:0];
			if (wrLanes) laneCount <= regWrData[4:0];
			if (wrEnh) enhancedFraming <= regWrData[0];
			if (wrPat) patternSel <= regWrData[1:0];
			if (wrByp) scrBypass <= regWrData[0];
			if (wrSRst) serdesReset <= regWrData[0];
			if (wrSRate) serdesRate <= regWrData[7:0];
		end
	end

	// transmitter, stream and line-code controls
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txEnable <= 1'b0;
			streamEnable <= 1'b0;
			streamAttributes <= 32'h0000_0000;
			lineCodeEnable <= `RST_LINE_CODE_CFG;
			forceScrReset <= 1'b0;
		end else begin
			if (wrTxEn) txEnable <= regWrData[0];
			if (wrStream) streamEnable <= regWrData[0];
			if (wrAttr) streamAttributes <= regWrData;
			if (wrLine) lineCodeEnable <= regWrData[0];
			forceScrReset <= wrForce && regWrData[0];
		end
	end

	// ready pins cross from the serdes; a change counts once stages agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			readySync1 <= 6'h00;
			readySync2 <= 6'h00;
			readySync3 <= 6'h00;
			readyFlags <= 6'h00;
		end else begin
			readySync1 <= serdesReadyPins;
			readySync2 <= readySync1;
			readySync3 <= readySync2;
			// held in reset the serdes reports nothing ready
			if (serdesReset)
				readyFlags <= 6'h00;
			else if (readySync2 == readySync3)
				readyFlags <= readySync3;
		end
	end

	// read mux: write-only and unmapped offsets read as zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdValid <= 1'b0;
			regRdData <= 32'h0000_0000;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn) begin
				case (regAddr)
				`OFS_LINK_RATE_CODE: regRdData <= {24'h0, linkRateCode};
				`OFS_LANE_COUNT: regRdData <= {27'h0, laneCount};
				`OFS_ENH_FRAMING: regRdData <= {31'h0, enhancedFraming};
				`OFS_TRAIN_PATTERN: regRdData <= {30'h0, patternSel};
				`OFS_SCR_BYPASS: regRdData <= {31'h0, scrBypass};
				`OFS_SERDES_RESET: regRdData <= {31'h0, serdesReset};
				`OFS_SERDES_RATE: regRdData <= {24'h0, serdesRate};
				`OFS_SERDES_READY: regRdData <= {26'h0, readyFlags};
				`OFS_TX_ENABLE: regRdData <= {31'h0, txEnable};
				`OFS_STREAM_ENABLE: regRdData <= {31'h0, streamEnable};
				`OFS_STREAM_ATTR: regRdData <= streamAttributes;
				`OFS_LINE_CODE_CFG: regRdData <= {31'h0, lineCodeEnable};
				default: regRdData <= 32'h0000_0000;
				endcase
			end
		end
	end

	// training state follows the selector without delay beyond one edge
	always_comb begin
		case (patternSel)
		`PAT_ONE: next_state = dp_tx_pkg::TRAIN_TP1;
		`PAT_TWO: next_state = dp_tx_pkg::TRAIN_TP2;
		`PAT_THREE: next_state = dp_tx_pkg::TRAIN_TP3;
		default: next_state = dp_tx_pkg::TRAIN_OFF;
		endcase
	end

	// state register and pattern phase; phase restarts on pattern change
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= dp_tx_pkg::TRAIN_OFF;
			phase <= 4'h0;
			trainingActive <= 1'b0;
		end else begin
			state <= next_state;
			trainingActive <= next_state != dp_tx_pkg::TRAIN_OFF;
			if (next_state != state || phase == `PHASE_LAST)
				phase <= 4'h0;
			else
				phase <= phase + 4'h1;
		end
	end

	// pattern 1 is all D10.2; pattern 2 leads with K28.5/D11.6 pairs
	// pattern 3 here alternates K28.5 and D10.2 so it stays distinct
	always_comb begin
		case (state)
		dp_tx_pkg::TRAIN_TP1: patSym = '{`SYM_D10_2, 1'b0};
		// conditional arms are plain concatenations: the symbol is packed
		dp_tx_pkg::TRAIN_TP2: begin
			if (phase < 4'h4)
				patSym = phase[0] ? {`SYM_D11_6, 1'b0} :
					{`SYM_K28_5, 1'b1};
			else
				patSym = '{`SYM_D10_2, 1'b0};
		end
		dp_tx_pkg::TRAIN_TP3: patSym = phase[0] ? {`SYM_D10_2, 1'b0} :
			{`SYM_K28_5, 1'b1};
		default: patSym = '{`SYM_IDLE, 1'b0};
		endcase
	end

	// training blocks video; video only passes with the stream enabled
	assign selSym = (state != dp_tx_pkg::TRAIN_OFF) ? patSym :
		(streamEnable ? {videoData, videoIsK} : {`SYM_IDLE, 1'b0});

	// blanking-start symbols counted only while the stream runs
	wire bsSeen = streamEnable && state == dp_tx_pkg::TRAIN_OFF &&
		videoIsK && videoData == `SYM_K28_0;
	wire bsReset = bsSeen && bsCount == `BS_PERIOD;

	always_ff @(posedge clk) begin
		if (!rst_n || forceScrReset) begin
			bsCount <= 9'h000;
		end else if (bsSeen) begin
			bsCount <= bsCount + 9'h001; // wraps after the 512th
		end
	end

	// patterns always go out plain; video honours the bypass setting
	assign scrBus.rawSym = selSym;
	assign scrBus.bypass = scrBypass || state != dp_tx_pkg::TRAIN_OFF;
	assign scrBus.seedReset = forceScrReset || bsReset;

	scrambler u_scrambler (
		.clk(clk),
		.rst_n(rst_n),
		.port(scrBus.scr)
	);

	// lane output: nothing leaves while the transmitter is off
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txData <= `SYM_IDLE;
			txIsK <= 1'b0;
		end else begin
			txData <= txEnable ? scrBus.lineSym.data : `SYM_IDLE;
			txIsK <= txEnable && scrBus.lineSym.isK;
		end
	end
endmodule
`default_nettype wire

//--- tb/dp_tx_link_ctrl_asserts.sv
// port assertions for the link control block
`default_nettype none
module dp_tx_link_ctrl_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic [31:0] regRdData,
	input wire logic [5:0] serdesReadyPins,
	input wire logic [7:0] videoData,
	input wire logic [7:0] txData,
	input wire logic txIsK,
	input wire logic serdesReset,
	input wire logic txEnable,
	input wire logic streamEnable,
	input wire logic trainingActive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] patSel;
	logic byp;
	// decodes of the accesses the checks key on
	wire patWr = regWrEn && regAddr == 12'h00C;
	wire bypWr = regWrEn && regAddr == 12'h010;
	wire rdReady = regRdEn && regAddr == 12'h024;
	wire sym = txData inside {8'h4A, 8'hBC, 8'hCB};
	// shadow of selector and bypass, since no port shows which pattern
	always_ff @(posedge clk) begin
		patSel <= !rst_n ? 2'h0 : patWr ? regWrData[1:0] : patSel;
		byp <= !rst_n ? 1'b0 : bypWr ? regWrData[0] : byp;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// the flag trails the selector register by one edge, so two in all
	sel_on_a:
		assert property (patWr && regWrData[1:0] != 2'h0 |-> ##2 trainingActive)
		else $error("selector write did not start training");
	sel_off_a:
		assert property (patWr && regWrData[1:0] == 2'h0 |-> ##2 !trainingActive)
		else $error("training still active after clear");
	video_blocked_a:
		assert property ((txEnable && trainingActive)[*3] |-> sym)
		else $error("non-pattern symbol during training");
	pat_one_a:
		assert property ((txEnable && patSel == 2'h1)[*4]
			|-> txData == 8'h4A && !txIsK)
		else $error("pattern one symbol wrong");
	pat_two_a:
		assert property ((txEnable && patSel == 2'h2)[*4]
			|-> sym && txIsK == (txData == 8'hBC))
		else $error("pattern two symbol wrong");
	pat_three_a:
		assert property ((txEnable && patSel == 2'h3)[*4]
			|-> txData != $past(txData))
		else $error("pattern three not alternating");
	video_plain_a:
		assert property ((txEnable && streamEnable && byp && patSel == 2'h0)[*4]
			|-> txData == $past(videoData, 2))
		else $error("bypassed video not passed through");
	ready_seen_a:
		assert property ((!serdesReset && serdesReadyPins == 6'h3F)[*8] ##0 rdReady
			|=> regRdData[5:0] == 6'h3F)
		else $error("ready flags not reported");
	ready_held_a:
		assert property (serdesReset[*2] ##0 rdReady |=> regRdData[5:0] == 6'h00)
		else $error("ready flags set in serdes reset");
	wo_read_a:
		assert property (regRdEn && regAddr == 12'h0C0
			|=> regRdData == 32'h0000_0000)
		else $error("force reset register read nonzero");
endmodule
bind dp_tx_link_ctrl dp_tx_link_ctrl_asserts u_dp_tx_link_ctrl_asserts (
	.clk, .rst_n, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
	.serdesReadyPins, .videoData, .txData, .txIsK, .serdesReset, .txEnable,
	.streamEnable, .trainingActive);
`default_nettype wire

//--- tb/serdes_model.sv
// serdes stand-in: lanes report ready a while after reset release
`default_nettype none
module serdes_model #(parameter int LOCK = 20) (
	input wire logic clk,
	input wire logic serdesReset,
	output logic [5:0] readyPins
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// pll lock time counted from release, restarted by every reset
	always_ff @(posedge clk) begin
		cnt <= serdesReset ? 0 : (cnt < LOCK ? cnt + 1 : cnt);
	end
	assign readyPins = (cnt == LOCK) ? 6'h3F : 6'h00;
endmodule
`default_nettype wire

//--- tb/test_dp_tx_link_ctrl.sv
// self-checking bench for the source link bring-up and training block
`default_nettype none
module test_dp_tx_link_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst_n = 0, regWrEn = 0, regRdEn = 0, videoIsK = 0;
	logic [11:0] regAddr = 0;
	logic [31:0] regWrData = 0, regRdData, streamAttributes, d;
	logic [7:0] videoData = 0, txData, serdesRate, linkRateCode;
	logic [5:0] serdesReadyPins;
	logic [4:0] laneCount;
	logic regRdValid, txIsK, serdesReset, txEnable, lineCodeEnable;
	logic enhancedFraming, streamEnable, trainingActive;
	int n_errors = 0, checks = 0;
	dp_tx_link_ctrl u_dp_tx_link_ctrl (.clk, .rst_n, .regWrEn, .regRdEn,
		.regAddr, .regWrData, .regRdData, .regRdValid, .serdesReadyPins,
		.videoData, .videoIsK, .txData, .txIsK, .serdesReset, .serdesRate,
		.txEnable, .lineCodeEnable, .laneCount, .linkRateCode,
		.enhancedFraming, .streamAttributes, .streamEnable, .trainingActive);
	serdes_model u_serdes_model (.clk, .serdesReset,
		.readyPins(serdesReadyPins));
	always #5 clk = ~clk;
	task automatic chk(input logic ok, input string m);
		checks++;
		if (!ok) begin
			n_errors++;
			$display("wrong value at %0t ns: %s", $time, m);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// strobes rise at a falling edge and stay for exactly one rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(negedge clk);
		regWrEn = 1;
		regAddr = a;
		regWrData = v;
		@(negedge clk);
		regWrEn = 0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(negedge clk);
		regRdEn = 1;
		regAddr = a;
		// valid stands one cycle only, so it is taken at the next fall
		@(negedge clk);
		chk(regRdValid === 1'b1, "read not answered");
		d = regRdData;
		regRdEn = 0;
	endtask
	task automatic t_regs;
		rd(12'h200);
		chk(d === 32'h1 && lineCodeEnable === 1'b1, "line code reset");
		rd(12'h300);
		chk(d === 32'h0, "unmapped read");
		wr(12'h0C0, 32'h0);
		rd(12'h0C0);
		chk(d === 32'h0, "write-only read");
		$display("test regs done");
	endtask
	task automatic t_setup;
		// sideband divider and interrupt mask sit outside this block
		wr(12'h01C, 32'h1);
		wr(12'h080, 32'h0);
		wr(12'h020, 32'h14);
		rd(12'h024);
		chk(d === 32'h0, "ready during reset");
		chk(serdesReset === 1'b1, "serdes not in reset");
		wr(12'h01C, 32'h0);
		d = 0;
		for (int i = 0; i < 40 && d !== 32'h3F; i++)
			rd(12'h024);
		chk(d === 32'h3F, "serdes never ready");
		if (d !== 32'h3F)
			end_sim();
		wr(12'h080, 32'h1);
		rd(12'h024);
		chk(txEnable === 1'b1 && d === 32'h3F, "tx enable");
		chk(serdesRate === 8'h14 && serdesReset === 1'b0, "serdes");
		$display("test setup done");
	endtask
	task automatic t_config;
		// sink capabilities are taken as read already
		wr(12'h004, 32'h4);
		wr(12'h000, 32'h14);
		wr(12'h008, 32'h1);
		wr(12'h180, 32'h12345678);
		rd(12'h180);
		chk(laneCount === 5'h4 && linkRateCode === 8'h14, "config");
		chk(enhancedFraming === 1'b1, "framing");
		chk(streamAttributes === 32'h12345678, "attrs");
		chk(d === 32'h12345678, "attrs read");
		$display("test config done");
	endtask
	// counts per ten symbols: D10.2, K28.5 for patterns one to three
	task automatic t_train;
		int n4A, nBC;
		int e4A[3] = '{10, 6, 5};
		int eBC[3] = '{0, 2, 5};
		videoData = 8'h55;
		// no sink stands here: it is taken as set to each pattern first
		// and passing at once, so no adjust or retry loop runs
		wr(12'h010, 32'h1);
		for (int p = 1; p < 4; p++) begin
			wr(12'h00C, 32'(p));
			repeat (3) @(negedge clk);
			n4A = 0;
			nBC = 0;
			for (int i = 0; i < 10; i++) begin
				n4A += int'(txData === 8'h4A);
				nBC += int'(txData === 8'hBC);
				@(negedge clk);
			end
			chk(trainingActive === 1'b1, "training flag");
			chk(n4A == e4A[p-1] && nBC == eBC[p-1], "pat");
		end
		wr(12'h084, 32'h1);
		wr(12'h00C, 32'h0);
		repeat (3) @(negedge clk);
		chk(trainingActive === 1'b0 && txData === 8'h55, "video");
		chk(streamEnable === 1'b1, "stream enable");
		$display("test train done");
	endtask
	// zero data after a reseed must come out as the all-ones key byte
	task automatic t_scramble;
		wr(12'h010, 32'h0);
		videoData = 8'h00;
		wr(12'h0C0, 32'h1);
		repeat (3) @(negedge clk);
		chk(txData === 8'hFF, "forced reseed");
		for (int i = 0; i < 512; i++) begin
			videoIsK = 1;
			videoData = 8'h1C;
			@(negedge clk);
		end
		videoIsK = 0;
		videoData = 8'h00;
		repeat (2) @(negedge clk);
		chk(txData === 8'hFF, "periodic reseed");
		$display("test scramble done");
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_n = 1;
		t_regs();
		t_setup();
		t_config();
		t_train();
		t_scramble();
		end_sim();
	end
endmodule
`default_nettype wire
